//--- endpoint_state_store.sv
// small store of the six per-endpoint state codes
`timescale 1ns/1ps
`include "usb_status_cfg.svh"

module endpoint_state_store (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [2:0] wrCode,
  output logic [17:0] states
);

  // ----------------------------------------------------------------
  // storage, read out from flip-flops
  // ----------------------------------------------------------------
  logic [17:0] states_q;
  logic [17:0] states_d;

  // only the addressed field changes; the others hold
  always_comb begin
    states_d = states_q;
    if (wrEn) begin
      states_d[wrIdx * 3 +: 3] = wrCode;
    end
  end

  // fields start at the neutral code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      states_q <= {`EP_COUNT{`STATE_RESET}};
    end else begin
      states_q <= states_d;
    end
  end

  assign states = states_q;

endmodule : endpoint_state_store

//--- usb_endpoint_status_report.sv
// transaction status word, event flags and interrupt of the usb device
//
// Functional notes
// - in ack reads 000, in nak 001, out with data0 acked 010.
// - out with data1 acked reads 110, setup ack 011, iso end 111.
// - endpoints 0..2 keep their codes in bits 10:8, 13:11, 16:14.
// - endpoints 3..5 keep their codes in bits 19:17, 22:20, 25:23.
// - bit 7 is set when out data exceed the endpoint max payload.
// - bit 7 is also set when setup data exceed eight bytes.
// - bits 31:26 read zero and the status word ignores writes.
// - bits 6:4 hold the code of the most recent event.
// - reading the status word clears the setup and endpoint flags.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "usb_status_cfg.svh"

module usb_endpoint_status_report (
  input wire logic clk,
  input wire logic rst,
  input usb_status_pkg::reg_req_s regReq,
  output logic [31:0] regRdata,
  input usb_status_pkg::txn_event_s txnEvent,
  input wire logic [59:0] maxPayload,
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // state code of a completed transaction
  function automatic logic [2:0] stateCode(
    input usb_status_pkg::txn_kind_e kind,
    input logic toggle
  );
    logic [2:0] code;
    code = `CODE_IN_ACK;
    unique case (kind)
      usb_status_pkg::KIND_IN_ACK: code = `CODE_IN_ACK;
      usb_status_pkg::KIND_IN_NAK: code = `CODE_IN_NAK;
      usb_status_pkg::KIND_OUT_ACK:
        code = toggle ? `CODE_OUT1_ACK : `CODE_OUT0_ACK;
      usb_status_pkg::KIND_SETUP_ACK: code = `CODE_SETUP_ACK;
      usb_status_pkg::KIND_ISO_END: code = `CODE_ISO_END;
      default: code = `CODE_IN_ACK;
    endcase
    return code;
  endfunction : stateCode

  // max payload of one endpoint, ten bits per endpoint
  function automatic logic [9:0] payloadOf(
    input logic [59:0] table_,
    input logic [2:0] idx
  );
    return table_[idx * 10 +: 10];
  endfunction : payloadOf

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  logic epInRange;
  logic evTake;
  logic [2:0] evIdx;
  logic [2:0] evCode;
  logic isOut;
  logic isSetup;
  logic outTooLong;
  logic setupTooLong;
  logic overrunHit;

  // endpoints above five do not exist; their events are dropped
  assign epInRange = (txnEvent.endpoint < 4'h6);
  assign evTake = txnEvent.valid && epInRange;
  assign evIdx = txnEvent.endpoint[2:0];
  assign evCode = stateCode(txnEvent.kind, txnEvent.toggle);
  assign isOut = (txnEvent.kind == usb_status_pkg::KIND_OUT_ACK);
  assign isSetup = (txnEvent.kind == usb_status_pkg::KIND_SETUP_ACK);
  assign outTooLong = isOut &&
    (txnEvent.byteCount > payloadOf(maxPayload, evIdx));
  assign setupTooLong = isSetup &&
    (txnEvent.byteCount > `SETUP_MAX_BYTES);
  assign overrunHit = evTake && (outTooLong || setupTooLong);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic hitStatus;
  logic hitFlags;
  logic hitMask;
  logic rdStatus;
  logic rdFlags;
  logic wrMask;

  assign hitStatus = (regReq.addr == `OFS_TXN_STATUS);
  assign hitFlags = (regReq.addr == `OFS_EVENT_FLAGS);
  assign hitMask = (regReq.addr == `OFS_EVENT_MASK);
  assign rdStatus = regReq.rd && hitStatus;
  assign rdFlags = regReq.rd && hitFlags;
  // status word has no write path at all
  assign wrMask = regReq.wr && hitMask;

  // ----------------------------------------------------------------
  // per-endpoint state codes
  // ----------------------------------------------------------------
  logic [17:0] epStates;

  // each endpoint field changes only on its own transaction
  endpoint_state_store u_store (
    .clk(clk),
    .rst(rst),
    .wrEn(evTake),
    .wrIdx(evIdx),
    .wrCode(evCode),
    .states(epStates)
  );

  // ----------------------------------------------------------------
  // last event state, endpoint number and overrun
  // ----------------------------------------------------------------
  logic [2:0] lastCode_q;
  logic [2:0] lastCode_d;
  logic [3:0] lastEp_q;
  logic [3:0] lastEp_d;
  logic overrun_q;
  logic overrun_d;

  assign lastCode_d = evTake ? evCode : lastCode_q;
  assign lastEp_d = evTake ? txnEvent.endpoint : lastEp_q;
  // overrun is sticky until the status word is read; a new hit wins
  assign overrun_d = overrunHit | (overrun_q & ~rdStatus);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastCode_q <= `STATE_RESET;
      lastEp_q <= 4'h0;
      overrun_q <= 1'b0;
    end else begin
      lastCode_q <= lastCode_d;
      lastEp_q <= lastEp_d;
      overrun_q <= overrun_d;
    end
  end

  // ----------------------------------------------------------------
  // status word assembly
  // ----------------------------------------------------------------
  logic [31:0] statusWord;

  // top six bits are constant zero
  assign statusWord = {6'h00, epStates, overrun_q, lastCode_q,
    lastEp_q};

  // ----------------------------------------------------------------
  // event flags (sticky, cleared by reading status or the flags)
  // ----------------------------------------------------------------
  logic setupFlag_q;
  logic setupFlag_d;
  logic [5:0] epFlags_q;
  logic [5:0] epFlags_d;
  logic [5:0] epHit;
  logic flagClear;
  logic [31:0] flagWord;

  assign epHit = evTake ? (6'h01 << evIdx) : 6'h00;
  // reading the status word clears the flags as well
  assign flagClear = rdStatus | rdFlags;
  // a flag set in the clearing cycle survives the clear
  assign setupFlag_d = (evTake && isSetup) |
    (setupFlag_q & ~flagClear);
  assign epFlags_d = epHit | (epFlags_q & {6{~flagClear}});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setupFlag_q <= 1'b0;
      epFlags_q <= 6'h00;
    end else begin
      setupFlag_q <= setupFlag_d;
      epFlags_q <= epFlags_d;
    end
  end

  assign flagWord = {setupFlag_q, 9'h000, epFlags_q, 16'h0000};

  // ----------------------------------------------------------------
  // interrupt mask and output
  // ----------------------------------------------------------------
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] maskValid;

  // only bits that exist in the flag word can be enabled
  assign maskValid = {1'b1, 9'h000, 6'h3f, 16'h0000};
  assign mask_d = wrMask ? (regReq.wdata & maskValid) : mask_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= `MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // level output, falls the cycle after the clearing read
  assign irq = |(flagWord & mask_q);

  // ----------------------------------------------------------------
  // read data, valid the cycle after the read strobe only
  // ----------------------------------------------------------------
  logic [31:0] readMux;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // unmapped addresses read as zero
  assign readMux = hitStatus ? statusWord :
                   hitFlags ? flagWord :
                   hitMask ? mask_q : 32'h00000000;
  assign rdata_d = regReq.rd ? readMux : 32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;

endmodule : usb_endpoint_status_report

//--- usb_endpoint_status_report_bench.sv
// self-checking bench of the transaction status word
`timescale 1ns/1ps
module usb_endpoint_status_report_bench;
  logic clk;
  logic rst;
  usb_status_pkg::reg_req_s regReq;
  logic [31:0] regRdata;
  usb_status_pkg::txn_event_s txnEvent;
  logic [59:0] maxPayload;
  logic irq;
  logic [31:0] d;
  logic [31:0] w;
  int errors;
  int checksDone;
  // endpoint, kind, toggle, byte count (at the limit for out and setup), expected code
  logic [20:0] rows [6] = '{{4'h0, 3'h0, 1'h0, 10'h0, 3'h0},
    {4'h1, 3'h1, 1'h0, 10'h0, 3'h1}, {4'h2, 3'h2, 1'h0, 10'h40, 3'h2},
    {4'h3, 3'h2, 1'h1, 10'h40, 3'h6}, {4'h4, 3'h3, 1'h0, 10'h8, 3'h3},
    {4'h5, 3'h4, 1'h0, 10'h10, 3'h7}};
  usb_endpoint_status_report usb_endpoint_status_report_inst (.clk(clk),
    .rst(rst), .regReq(regReq), .regRdata(regRdata), .txnEvent(txnEvent),
    .maxPayload(maxPayload), .irq(irq));
  usb_host usb_host_inst (.clk(clk), .txnEvent(txnEvent));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string n, input logic [31:0] s, e);
    checksDone++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check
  // one-cycle strobes; read data are taken in the cycle after
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    regReq <= {a, v, 2'h2};
    @(posedge clk);
    regReq.wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    regReq <= {a, 32'h0, 2'h1};
    @(posedge clk);
    regReq.rd <= 1'h0;
    #1 d = regRdata;
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // bounded run; a hang counts as a mismatch
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial begin
    rst = 1'h1;
    regReq = '0;
    maxPayload = {6{10'h040}};
    errors = 0;
    checksDone = 0;
    w = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rd(12'h00c);
    check("reset", d, 32'h0);
    $display("reset done");
    // each code once, one endpoint each; out and setup counts sit on the limit
    foreach (rows[i]) begin
      usb_host_inst.send(rows[i][20:17], rows[i][16:14], rows[i][13],
        rows[i][12:3]);
      w[8 + 3 * i +: 3] = rows[i][2:0];
      w[7:0] = {1'h0, rows[i][2:0], rows[i][20:17]};
      rd(12'h00c);
      check("row", d, w);
    end
    $display("rows done");
    // unmasked setup overrun raises irq; reading the flags drops it
    wr(12'h0a0, 32'h803f0000);
    rd(12'h0a0);
    check("mask", d, 32'h803f0000);
    usb_host_inst.send(4'h4, 3'h3, 1'h0, 10'h009);
    #1 check("irq", {31'h0, irq}, 32'h1);
    rd(12'h004);
    check("flags", d, 32'h80100000);
    check("irq", {31'h0, irq}, 32'h0);
    w[7:0] = 8'hb4;
    rd(12'h00c);
    check("setup over", d, w);
    $display("irq done");
    // masked out overrun; the status read clears flags and overrun
    wr(12'h0a0, 32'h0);
    usb_host_inst.send(4'h2, 3'h2, 1'h0, 10'h041);
    #1 check("masked", {31'h0, irq}, 32'h0);
    w[7:0] = 8'ha2;
    rd(12'h00c);
    check("out over", d, w);
    rd(12'h004);
    check("cleared", d, 32'h0);
    usb_host_inst.send(4'h0, 3'h3, 1'h0, 10'h009);
    w[10:8] = 3'h3;
    w[7:0] = 8'hb0;
    rd(12'h00c);
    check("ep0 setup", d, w);
    $display("overrun done");
    // endpoint 6 ignored, status word not writable, unmapped reads 0
    usb_host_inst.send(4'h6, 3'h1, 1'h0, 10'h000);
    wr(12'h00c, 32'hffffffff);
    rd(12'h0f0);
    check("unmapped", d, 32'h0);
    w[7] = 1'h0;
    rd(12'h00c);
    check("read only", d, w);
    // read data stand one cycle only, then the port idles at zero
    @(posedge clk);
    #1 check("rdata idle", regRdata, 32'h0);
    $display("access done");
    // a status read drops irq; an event beside the read keeps its flag
    wr(12'h0a0, 32'h803f0000);
    usb_host_inst.send(4'h1, 3'h0, 1'h0, 10'h000);
    #1 check("irq set", {31'h0, irq}, 32'h1);
    w[13:11] = 3'h0;
    w[7:0] = 8'h01;
    rd(12'h00c);
    check("ep1 in", d, w);
    check("irq clr", {31'h0, irq}, 32'h0);
    fork
      usb_host_inst.send(4'h3, 3'h1, 1'h0, 10'h000);
      rd(12'h00c);
    join
    check("race read", d, w);
    check("set wins", {31'h0, irq}, 32'h1);
    rd(12'h004);
    check("race flag", d, 32'h00080000);
    w[19:17] = 3'h1;
    w[7:0] = 8'h13;
    rd(12'h00c);
    check("ep3 nak", d, w);
    $display("clear done");
    end_of_test();
  end
endmodule : usb_endpoint_status_report_bench

//--- usb_host.sv
// behavioural usb host standing in for the transaction results
`timescale 1ns/1ps
module usb_host (
  input wire logic clk,
  output usb_status_pkg::txn_event_s txnEvent
);
  initial txnEvent = '0;
  // one result for one cycle; released fields flip so stale data shows
  task automatic send(input logic [3:0] p, input logic [2:0] k,
      input logic t, input logic [9:0] c);
    @(posedge clk);
    txnEvent <= {1'h1, p, k, t, c};
    @(posedge clk);
    txnEvent <= {1'h0, ~txnEvent[17:0]};
  endtask : send
endmodule : usb_host

//--- usb_status_cfg.svh
// offsets, field positions, codes and reset values of the status block
`ifndef USB_STATUS_CFG_SVH
`define USB_STATUS_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_EVENT_FLAGS 12'h004
`define OFS_TXN_STATUS 12'h00c
`define OFS_EVENT_MASK 12'h0a0

// ----------------------------------------------------------------
// status word layout
// ----------------------------------------------------------------
`define EP_COUNT 6
`define EP_FIELD_LSB 8
`define EP_FIELD_W 3
`define OVERRUN_BIT 7
`define TXN_STATE_LSB 4
`define EP_NUM_LSB 0

// ----------------------------------------------------------------
// event flag layout
// ----------------------------------------------------------------
`define SETUP_FLAG_BIT 31
`define EP_FLAG_LSB 16

// ----------------------------------------------------------------
// state codes and limits
// ----------------------------------------------------------------
`define CODE_IN_ACK 3'h0
`define CODE_IN_NAK 3'h1
`define CODE_OUT0_ACK 3'h2
`define CODE_OUT1_ACK 3'h6
`define CODE_SETUP_ACK 3'h3
`define CODE_ISO_END 3'h7
`define SETUP_MAX_BYTES 10'h008
`define STATE_RESET 3'h0
`define MASK_RESET 32'h00000000

`endif

//--- usb_status_pkg.sv
// types shared by the transaction status block
package usb_status_pkg;

  // kind of completed transaction reported by the serial engine
  typedef enum logic [2:0] {
    KIND_IN_ACK = 3'h0,
    KIND_IN_NAK = 3'h1,
    KIND_OUT_ACK = 3'h2,
    KIND_SETUP_ACK = 3'h3,
    KIND_ISO_END = 3'h4
  } txn_kind_e;

  // one transaction result, valid for one cycle
  typedef struct packed {
    logic valid;
    logic [3:0] endpoint;
    txn_kind_e kind;
    logic toggle;
    logic [9:0] byteCount;
  } txn_event_s;

  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage : usb_status_pkg

//--- usb_status_properties.sv
// port assertions of the transaction status block
`timescale 1ns/1ps
module usb_status_properties (
  input wire logic clk,
  input wire logic rst,
  input usb_status_pkg::reg_req_s regReq,
  input wire logic [31:0] regRdata,
  input usb_status_pkg::txn_event_s txnEvent,
  input wire logic [59:0] maxPayload,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // qualified event, status read and the code an event should leave
  wire [3:0] ep = txnEvent.endpoint;
  wire ev = txnEvent.valid && ep < 4'h6;
  wire rdS = regReq.rd && regReq.addr == 12'h00c && !txnEvent.valid;
  wire isOut = txnEvent.kind == 3'h2;
  wire [2:0] code = isOut ? {txnEvent.toggle, 2'h2} :
    txnEvent.kind == 3'h4 ? 3'h7 : txnEvent.kind;
  wire over = txnEvent.byteCount > maxPayload[ep * 10 +: 10];
  logic [3:0] lastEp_q;
  logic [2:0] code_q;
  // last event kept so a later read can be judged against it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastEp_q <= 4'h0;
      code_q <= 3'h0;
    end else if (ev) begin
      lastEp_q <= ep;
      code_q <= code;
    end
  end
  // a quiet cycle, then a status read
  sequence after;
    !txnEvent.valid && !regReq.rd ##1 rdS;
  endsequence
  AST_CODE:
    assert property (ev ##1 after |=> regRdata[6:4] == code_q)
    else $error("bad code");
  AST_EPNUM:
    assert property (ev ##1 after |=> regRdata[3:0] == lastEp_q)
    else $error("bad endpoint");
  AST_EPLO:
    assert property (ev && ep < 4'h3 ##1 after
      |=> regRdata[lastEp_q * 3 + 8 +: 3] == code_q)
    else $error("bad low field");
  AST_EPHI:
    assert property (ev && ep > 4'h2 ##1 after
      |=> regRdata[lastEp_q * 3 + 8 +: 3] == code_q)
    else $error("bad high field");
  AST_RSVD:
    assert property (rdS |=> regRdata[31:26] == 6'h00)
    else $error("reserved set");
  AST_OVR_OUT:
    assert property (ev && isOut && over ##1 after |=> regRdata[7])
    else $error("out overrun");
  AST_OVR_SETUP:
    assert property (ev && txnEvent.kind == 3'h3 &&
      txnEvent.byteCount > 10'h008 ##1 after |=> regRdata[7])
    else $error("setup overrun");
  AST_IRQ:
    assert property (rdS |=> !irq)
    else $error("irq kept");
  // read data only stand in the cycle after a read strobe
  AST_RD_IDLE:
    assert property (!regReq.rd |=> regRdata == 32'h0)
    else $error("read data kept");
endmodule : usb_status_properties

bind usb_endpoint_status_report usb_status_properties chk (.clk(clk),
  .rst(rst), .regReq(regReq), .regRdata(regRdata), .txnEvent(txnEvent),
  .maxPayload(maxPayload), .irq(irq));
